/* src/hso_pkg.sv */
// Package with constants and types for the high-side output control block.
// Summary of operation
// - Six outputs, each own 10-bit PWM generator.
// - Frequency code picks 108/217/289/434 Hz period.
// - Source code 11 selects internal generator.
// - Constant-current mode limits current for 10ms.
// - Limit select bit picks low or high limit.
// - Enable only while off; timer starts on source.
// - After expiry output follows enable and source.
// - Early clear switches immediately; late set ignored.
// - Overcurrent detection only when on, not constant-current.
// - Regulation disabled at reset; first and group enables.
// - Without regulation, deglitched overcurrent turns output off.
// - With regulation, trip off, retry next period.
// - Overcurrent ignored for 40us after switch-on.
// - First output own settings; group shares one pair.
// - Deglitch starts after blank; code 48/40/32/24us.
// - Supply above 20V forces 10us deglitch.
// - Regulation trip latches status until clear fault.
// - Regulated output on at least blank plus deglitch.
// - Source 00 off, 01 register, 10 external pin.
package hso_pkg;

   localparam int NUM_OUT = 6;
   localparam int CLK_HZ  = 125000000;
   localparam int CLK_MHZ = 125;

   // Register indices.
   localparam logic [3:0] ADDR_FREQ    = 4'h0;
   localparam logic [3:0] ADDR_DUTY0   = 4'h1;
   localparam logic [3:0] ADDR_SOURCE  = 4'h7;
   localparam logic [3:0] ADDR_ONCTL   = 4'h8;
   localparam logic [3:0] ADDR_CCCFG   = 4'h9;
   localparam logic [3:0] ADDR_REG1    = 4'hA;
   localparam logic [3:0] ADDR_REG3    = 4'hB;
   localparam logic [3:0] ADDR_STATUS  = 4'hC;
   localparam logic [3:0] ADDR_CLRFLT  = 4'hD;
   localparam logic [3:0] ADDR_STATE   = 4'hE;

   // Field positions.
   localparam int CC_LIMIT_POS  = 8;
   localparam int REG_EN_POS    = 0;
   localparam int REG_FREQ_POS  = 8;
   localparam int REG_DG_POS    = 10;

   // Control source codes.
   localparam logic [1:0] SRC_OFF = 2'h0;
   localparam logic [1:0] SRC_REG = 2'h1;
   localparam logic [1:0] SRC_PIN = 2'h2;
   localparam logic [1:0] SRC_GEN = 2'h3;

   localparam logic [9:0] DUTY_MAX = 10'h3FE;

   // Generator step length per frequency code, one step is period / 1024.
   localparam int GEN_HZ0 = 108;
   localparam int GEN_HZ1 = 217;
   localparam int GEN_HZ2 = 289;
   localparam int GEN_HZ3 = 434;
   localparam logic [11:0] GEN_STEP0 = 12'(CLK_HZ / (GEN_HZ0 * 1024));
   localparam logic [11:0] GEN_STEP1 = 12'(CLK_HZ / (GEN_HZ1 * 1024));
   localparam logic [11:0] GEN_STEP2 = 12'(CLK_HZ / (GEN_HZ2 * 1024));
   localparam logic [11:0] GEN_STEP3 = 12'(CLK_HZ / (GEN_HZ3 * 1024));

   // Timing figures in their own units and derived cycle counts.
   localparam int CC_TIME_MS  = 10;
   localparam int CC_CYCLES   = CC_TIME_MS * (CLK_HZ / 1000);
   localparam int BLANK_US    = 40;
   localparam logic [12:0] BLANK_CYC = 13'(BLANK_US * CLK_MHZ);
   localparam int DG_US0 = 48;
   localparam int DG_US1 = 40;
   localparam int DG_US2 = 32;
   localparam int DG_US3 = 24;
   localparam int DG_US_HV = 10;
   localparam logic [12:0] DG_CYC0   = 13'(DG_US0 * CLK_MHZ);
   localparam logic [12:0] DG_CYC1   = 13'(DG_US1 * CLK_MHZ);
   localparam logic [12:0] DG_CYC2   = 13'(DG_US2 * CLK_MHZ);
   localparam logic [12:0] DG_CYC3   = 13'(DG_US3 * CLK_MHZ);
   localparam logic [12:0] DG_CYC_HV = 13'(DG_US_HV * CLK_MHZ);

   // Regulation period figures, per frequency code.
   localparam int RP_US0 = 10000;
   localparam int RP_US1 = 5000;
   localparam int RP_US2 = 2500;
   localparam int RP_US3 = 1250;
   localparam int RP_CYC0 = RP_US0 * CLK_MHZ;
   localparam int RP_CYC1 = RP_US1 * CLK_MHZ;
   localparam int RP_CYC2 = RP_US2 * CLK_MHZ;
   localparam int RP_CYC3 = RP_US3 * CLK_MHZ;

   typedef enum logic [1:0] {
      ST_OFF,
      ST_CC,
      ST_RUN,
      ST_TRIPPED
   } hso_state_t;

   // Register bus request.
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [3:0]  addr;
      logic [15:0] wdata;
   } hso_bus_t;

   // Per-output drive and status.
   typedef struct packed {
      logic [NUM_OUT-1:0] drive;
      logic [NUM_OUT-1:0] ccActive;
      logic [NUM_OUT-1:0] ccLimitHigh;
   } hso_drv_t;

endpackage

/* src/hso_control.sv */
// High-side output control: generators, timed current mode, regulation.
`timescale 1ns/1ps
module hso_control #(
   parameter int CC_TIME_CYC = hso_pkg::CC_CYCLES,
   parameter int RP_SCALE    = 1
) (
   // Clock and reset.
   input  wire logic              clock,
   input  wire logic              srst,
   // Register port.
   input  wire hso_pkg::hso_bus_t bus,
   output      logic [15:0]       rdata,
   // Analog status and external pin.
   input  wire logic [5:0]        overcurrent,
   input  wire logic              supplyHigh,
   input  wire logic              externalPwmPin,
   // Driver controls.
   output      hso_pkg::hso_drv_t drv
);

   ////////////////////////////////////////////////////////////////////////
   // Helper functions.

   // Generator step length for a frequency code.
   function automatic logic [11:0] genStep(input logic [1:0] code);
      case (code)
         2'h0: genStep = hso_pkg::GEN_STEP0;
         2'h1: genStep = hso_pkg::GEN_STEP1;
         2'h2: genStep = hso_pkg::GEN_STEP2;
         default: genStep = hso_pkg::GEN_STEP3;
      endcase
   endfunction

   // Deglitch length for a code, forced short on high supply.
   function automatic logic [12:0] dgLen(input logic [1:0] code,
                                         input logic hv);
      if (hv) begin
         dgLen = hso_pkg::DG_CYC_HV;
      end else begin
         case (code)
            2'h0: dgLen = hso_pkg::DG_CYC0;
            2'h1: dgLen = hso_pkg::DG_CYC1;
            2'h2: dgLen = hso_pkg::DG_CYC2;
            default: dgLen = hso_pkg::DG_CYC3;
         endcase
      end
   endfunction

   // Regulation period length for a code.
   function automatic logic [23:0] rpLen(input logic [1:0] code);
      int v;
      v = 0;
      case (code)
         2'h0: v = hso_pkg::RP_CYC0 / RP_SCALE;
         2'h1: v = hso_pkg::RP_CYC1 / RP_SCALE;
         2'h2: v = hso_pkg::RP_CYC2 / RP_SCALE;
         default: v = hso_pkg::RP_CYC3 / RP_SCALE;
      endcase
      rpLen = 24'(v);
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Registers.

   logic [11:0] freqSel_q;
   logic [9:0]  duty_q [6];
   logic [11:0] source_q;
   logic [5:0]  onBit_q;
   logic [5:0]  ccEn_q;
   logic [5:0]  ccLimit_q;
   logic        firstRegEn_q;
   logic [1:0]  firstFreq_q;
   logic [1:0]  firstDg_q;
   logic [4:0]  groupRegEn_q;
   logic [1:0]  groupFreq_q;
   logic [1:0]  groupDg_q;
   logic [5:0]  tripStat_q;
   logic [15:0] rdata_q;
   hso_pkg::hso_state_t st_q [6];
   logic [5:0]  tripEvent;
   logic [5:0]  ccLateSet;

   wire wrSrc  = bus.wr && bus.addr == hso_pkg::ADDR_SOURCE;
   wire wrCc   = bus.wr && bus.addr == hso_pkg::ADDR_CCCFG;
   wire clrFlt = bus.wr && bus.addr == hso_pkg::ADDR_CLRFLT
                 && bus.wdata[0];

   always_ff @(posedge clock) begin
      if (srst) begin
         freqSel_q    <= 12'h000;
         source_q     <= 12'h000;
         onBit_q      <= 6'h00;
         ccLimit_q    <= 6'h00;
         firstRegEn_q <= 1'b0;
         firstFreq_q  <= 2'h0;
         firstDg_q    <= 2'h0;
         groupRegEn_q <= 5'h00;
         groupFreq_q  <= 2'h0;
         groupDg_q    <= 2'h0;
         for (int i = 0; i < 6; i++) begin
            duty_q[i] <= 10'h000;
         end
      end else if (bus.wr) begin
         if (bus.addr == hso_pkg::ADDR_FREQ) begin
            freqSel_q <= bus.wdata[11:0];
         end else if (bus.addr >= hso_pkg::ADDR_DUTY0
                      && bus.addr < hso_pkg::ADDR_SOURCE) begin
            duty_q[3'(bus.addr - hso_pkg::ADDR_DUTY0)] <= bus.wdata[9:0];
         end else if (bus.addr == hso_pkg::ADDR_SOURCE) begin
            source_q <= bus.wdata[11:0];
         end else if (bus.addr == hso_pkg::ADDR_ONCTL) begin
            onBit_q <= bus.wdata[5:0];
         end else if (bus.addr == hso_pkg::ADDR_CCCFG) begin
            ccLimit_q <= bus.wdata[hso_pkg::CC_LIMIT_POS +: 6];
         end else if (bus.addr == hso_pkg::ADDR_REG1) begin
            firstRegEn_q <= bus.wdata[hso_pkg::REG_EN_POS];
            firstFreq_q  <= bus.wdata[hso_pkg::REG_FREQ_POS +: 2];
            firstDg_q    <= bus.wdata[hso_pkg::REG_DG_POS +: 2];
         end else if (bus.addr == hso_pkg::ADDR_REG3) begin
            groupRegEn_q <= bus.wdata[hso_pkg::REG_EN_POS +: 5];
            groupFreq_q  <= bus.wdata[hso_pkg::REG_FREQ_POS +: 2];
            groupDg_q    <= bus.wdata[hso_pkg::REG_DG_POS +: 2];
         end
      end
   end

   // Constant-current enable: taken only while the output is off.
   always_ff @(posedge clock) begin
      if (srst) begin
         ccEn_q <= 6'h00;
      end else begin
         for (int i = 0; i < 6; i++) begin
            if (wrCc) begin
               ccEn_q[i] <= bus.wdata[i] && (st_q[i] == hso_pkg::ST_OFF
                            || ccEn_q[i]);
            end else if (ccLateSet[i]) begin
               ccEn_q[i] <= 1'b0;
            end
         end
      end
   end

   // Trip status: set wins over clear.
   always_ff @(posedge clock) begin
      if (srst) begin
         tripStat_q <= 6'h00;
      end else begin
         tripStat_q <= (clrFlt ? 6'h00 : tripStat_q) | tripEvent;
      end
   end

   // Read data one cycle after the strobe.
   always_ff @(posedge clock) begin
      if (srst) begin
         rdata_q <= 16'h0000;
      end else if (bus.rd) begin
         if (bus.addr == hso_pkg::ADDR_FREQ) begin
            rdata_q <= {4'h0, freqSel_q};
         end else if (bus.addr >= hso_pkg::ADDR_DUTY0
                      && bus.addr < hso_pkg::ADDR_SOURCE) begin
            rdata_q <= {6'h00, duty_q[3'(bus.addr - hso_pkg::ADDR_DUTY0)]};
         end else if (bus.addr == hso_pkg::ADDR_SOURCE) begin
            rdata_q <= {4'h0, source_q};
         end else if (bus.addr == hso_pkg::ADDR_ONCTL) begin
            rdata_q <= {10'h000, onBit_q};
         end else if (bus.addr == hso_pkg::ADDR_CCCFG) begin
            rdata_q <= {2'h0, ccLimit_q, 2'h0, ccEn_q};
         end else if (bus.addr == hso_pkg::ADDR_REG1) begin
            rdata_q <= {4'h0, firstDg_q, firstFreq_q, 7'h00, firstRegEn_q};
         end else if (bus.addr == hso_pkg::ADDR_REG3) begin
            rdata_q <= {4'h0, groupDg_q, groupFreq_q, 3'h0, groupRegEn_q};
         end else if (bus.addr == hso_pkg::ADDR_STATUS) begin
            rdata_q <= {10'h000, tripStat_q};
         end else if (bus.addr == hso_pkg::ADDR_STATE) begin
            rdata_q <= {4'h0, 2'(st_q[5]), 2'(st_q[4]), 2'(st_q[3]),
                        2'(st_q[2]), 2'(st_q[1]), 2'(st_q[0])};
         end else begin
            rdata_q <= 16'h0000;
         end
      end
   end
   assign rdata = rdata_q;

   ////////////////////////////////////////////////////////////////////////
   // Per-output logic.

   logic [5:0] drive_q;
   logic [5:0] ccAct_q;

   for (genvar g = 0; g < 6; g++) begin : gOut
      logic [11:0] stepCnt_q;
      logic [9:0]  phase_q;
      logic        genOn_q;
      logic [23:0] ccCnt_q;
      logic [12:0] tmr_q;
      logic        blank_q;
      logic [23:0] rpCnt_q;
      logic [1:0]  src;
      logic        regEn;
      logic [1:0]  rfreq;
      logic [1:0]  rdg;
      logic        cmdOn;
      logic        periodEnd;
      logic        onNow;

      assign src   = source_q[2*g +: 2];
      assign regEn = (g == 0) ? firstRegEn_q : groupRegEn_q[(g == 0) ? 0 : g-1];
      assign rfreq = (g == 0) ? firstFreq_q : groupFreq_q;
      assign rdg   = (g == 0) ? firstDg_q : groupDg_q;
      // Command from the selected source.
      assign cmdOn = (src == hso_pkg::SRC_REG) ? onBit_q[g]
                   : (src == hso_pkg::SRC_PIN) ? externalPwmPin
                   : (src == hso_pkg::SRC_GEN) ? genOn_q : 1'b0;
      assign periodEnd = rpCnt_q >= rpLen(rfreq) - 24'h1;
      assign onNow = (st_q[g] == hso_pkg::ST_RUN) && cmdOn;
      assign ccLateSet[g] = st_q[g] == hso_pkg::ST_CC
                            && ccCnt_q >= 24'(CC_TIME_CYC - 1);
      assign tripEvent[g] = onNow && !blank_q && overcurrent[g]
                            && tmr_q >= dgLen(rdg, supplyHigh) - 13'h1
                            && regEn;

      // Internal generator: 1024 steps per period.
      always_ff @(posedge clock) begin
         if (srst) begin
            stepCnt_q <= 12'h000;
            phase_q   <= 10'h000;
            genOn_q   <= 1'b0;
         end else begin
            if (stepCnt_q >= genStep(freqSel_q[2*g +: 2]) - 12'h1) begin
               stepCnt_q <= 12'h000;
               phase_q   <= phase_q + 10'h001;
            end else begin
               stepCnt_q <= stepCnt_q + 12'h001;
            end
            genOn_q <= phase_q < duty_q[g];
         end
      end

      // Output state machine.
      always_ff @(posedge clock) begin
         if (srst) begin
            st_q[g] <= hso_pkg::ST_OFF;
            ccCnt_q <= 24'h000000;
         end else begin
            case (st_q[g])
               hso_pkg::ST_OFF: begin
                  ccCnt_q <= 24'h000000;
                  if (wrSrc && bus.wdata[2*g +: 2] != 2'h0
                      && ccEn_q[g]) begin
                     st_q[g] <= hso_pkg::ST_CC;
                  end else if (src != 2'h0) begin
                     st_q[g] <= hso_pkg::ST_RUN;
                  end
               end
               hso_pkg::ST_CC: begin
                  ccCnt_q <= ccCnt_q + 24'h000001;
                  if (src == 2'h0) begin
                     st_q[g] <= hso_pkg::ST_OFF;
                  end else if (!ccEn_q[g] || ccLateSet[g]) begin
                     st_q[g] <= hso_pkg::ST_RUN;
                  end
               end
               hso_pkg::ST_RUN: begin
                  if (src == 2'h0) begin
                     st_q[g] <= hso_pkg::ST_OFF;
                  end else if (onNow && !blank_q && overcurrent[g]
                        && tmr_q >= dgLen(rdg, supplyHigh) - 13'h1) begin
                     st_q[g] <= hso_pkg::ST_TRIPPED;
                  end
               end
               default: begin
                  if (src == 2'h0) begin
                     st_q[g] <= hso_pkg::ST_OFF;
                  end else if (regEn && periodEnd) begin
                     st_q[g] <= hso_pkg::ST_RUN;
                  end else if (!regEn && clrFlt) begin
                     st_q[g] <= hso_pkg::ST_OFF;
                  end
               end
            endcase
         end
      end

      // Blank then deglitch timing; re-armed at each switch-on.
      always_ff @(posedge clock) begin
         if (srst) begin
            tmr_q   <= 13'h0000;
            blank_q <= 1'b1;
         end else if (!onNow) begin
            tmr_q   <= 13'h0000;
            blank_q <= 1'b1;
         end else if (blank_q) begin
            if (tmr_q >= hso_pkg::BLANK_CYC - 13'h1) begin
               blank_q <= 1'b0;
               tmr_q   <= 13'h0000;
            end else begin
               tmr_q <= tmr_q + 13'h0001;
            end
         end else if (overcurrent[g]) begin
            tmr_q <= tmr_q + 13'h0001;
         end else begin
            tmr_q <= 13'h0000;
         end
      end

      // Regulation period counter.
      always_ff @(posedge clock) begin
         if (srst || periodEnd) begin
            rpCnt_q <= 24'h000000;
         end else begin
            rpCnt_q <= rpCnt_q + 24'h000001;
         end
      end

      always_ff @(posedge clock) begin
         if (srst) begin
            drive_q[g] <= 1'b0;
            ccAct_q[g] <= 1'b0;
         end else begin
            drive_q[g] <= onNow || st_q[g] == hso_pkg::ST_CC;
            ccAct_q[g] <= st_q[g] == hso_pkg::ST_CC;
         end
      end
   end

   assign drv.drive       = drive_q;
   assign drv.ccActive    = ccAct_q;
   assign drv.ccLimitHigh = ccLimit_q;

endmodule

/* verification/hso_control_chk.sv */
// Port assertions for the high-side output control block.
`timescale 1ns/1ps
module hso_control_chk #(
   parameter int CC_TIME_CYC = 200
) (
   // Clock and reset.
   input wire logic              clock,
   input wire logic              srst,
   // Register port and pins.
   input wire hso_pkg::hso_bus_t bus,
   input wire logic [15:0]       rdata,
   input wire logic [5:0]        overcurrent,
   input wire logic              supplyHigh,
   input wire logic              externalPwmPin,
   // Driver controls.
   input wire hso_pkg::hso_drv_t drv
);
   logic [1:0]  src0Q;
   logic        on0Q;
   logic        oc0Q;
   logic [15:0] onCntQ;
   logic [23:0] ccCntQ;
   logic        wrSrc;
   logic        wrCc;
   assign wrSrc = bus.wr && bus.addr == hso_pkg::ADDR_SOURCE;
   assign wrCc  = bus.wr && bus.addr == hso_pkg::ADDR_CCCFG;
   // Shadows of the first output's setup and counts of its states.
   always_ff @(posedge clock) begin
      if (srst) begin
         src0Q <= 2'h0;
         on0Q  <= 1'b0;
         oc0Q  <= 1'b0;
      end else begin
         if (wrSrc)
            src0Q <= bus.wdata[1:0];
         if (bus.wr && bus.addr == hso_pkg::ADDR_ONCTL)
            on0Q <= bus.wdata[0];
         if (overcurrent[0])
            oc0Q <= 1'b1;
         else if (bus.wr && bus.addr == hso_pkg::ADDR_CLRFLT)
            oc0Q <= 1'b0;
      end
      onCntQ <= (srst || !drv.drive[0]) ? 16'h0000 : onCntQ + 16'h0001;
      ccCntQ <= (srst || !drv.ccActive[0]) ? 24'h000000 : ccCntQ + 24'h000001;
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (srst);
   property p_rst;
      disable iff (1'b0) srst |=> drv.drive == 6'h00 && drv.ccActive == 6'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("drive in reset");
   property p_pin;
      src0Q == hso_pkg::SRC_PIN && !oc0Q && $rose(externalPwmPin) && !wrSrc
         |-> ##[1:2] drv.drive[0];
   endproperty
   a_pin: assert property (p_pin) else $error("pin not followed");
   property p_reg;
      bus.wr && bus.addr == hso_pkg::ADDR_ONCTL && bus.wdata[0] && !oc0Q
         && src0Q == hso_pkg::SRC_REG |-> ##[1:2] drv.drive[0];
   endproperty
   a_reg: assert property (p_reg) else $error("on bit ignored");
   property p_ccLen;
      ccCntQ <= CC_TIME_CYC + 2;
   endproperty
   a_ccLen: assert property (p_ccLen) else $error("timed mode long");
   property p_ccLate;
      drv.drive[0] && !drv.ccActive[0] && wrCc && bus.wdata[0]
         |=> !drv.ccActive[0] [*3];
   endproperty
   a_ccLate: assert property (p_ccLate) else $error("late enable");
   property p_ccClr;
      drv.ccActive[0] && wrCc && !bus.wdata[0] |-> ##[1:3] !drv.ccActive[0];
   endproperty
   a_ccClr: assert property (p_ccClr) else $error("early clear");
   property p_limit;
      wrCc |=> drv.ccLimitHigh == $past(bus.wdata[13:8]);
   endproperty
   a_limit: assert property (p_limit) else $error("limit bits");
   property p_ocMin;
      $fell(drv.drive[0]) && on0Q && src0Q == hso_pkg::SRC_REG
         |-> onCntQ >= 16'h1838;
   endproperty
   a_ocMin: assert property (p_ocMin) else $error("on time short");
endmodule
bind hso_control hso_control_chk #(.CC_TIME_CYC(CC_TIME_CYC)) chk_u (
   .clock(clock), .srst(srst), .bus(bus), .rdata(rdata),
   .overcurrent(overcurrent), .supplyHigh(supplyHigh),
   .externalPwmPin(externalPwmPin), .drv(drv));

/* verification/hso_host.sv */
// Host model driving the register port and the external pin.
`timescale 1ns/1ps
module hso_host (
   // Clock and read data.
   input  wire logic         clock,
   input  wire logic [15:0]  rdata,
   // Requests to the device.
   output hso_pkg::hso_bus_t bus,
   output logic              externalPwmPin
);
   initial begin
      bus = '0;
      externalPwmPin = 1'b0;
   end
   // One strobe, one idle cycle; read data are taken after the strobe.
   task automatic xfer(input logic w, input logic [3:0] a,
                       input logic [15:0] d, output logic [15:0] q);
      bus <= '{w, !w, a, d};
      @(posedge clock);
      bus <= '0;
      @(posedge clock);
      q = rdata;
   endtask
   // Duty codes are clamped to the top value.
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      logic [15:0] q;
      if (a >= hso_pkg::ADDR_DUTY0 && a < hso_pkg::ADDR_SOURCE
          && d > 16'(hso_pkg::DUTY_MAX))
         d = 16'(hso_pkg::DUTY_MAX);
      xfer(1'b1, a, d, q);
   endtask
   task automatic pin(input logic v);
      externalPwmPin <= v;
   endtask
endmodule

/* verification/hso_control_tb.sv */
// Self-checking bench for the high-side output control block.
`timescale 1ns/1ps
module hso_control_tb;
   typedef struct {
      logic [1:0] src;
      logic       on;
      logic       pin;
      logic       exp;
   } hso_row_t;
   localparam int CC_T = 200;
   localparam int RP   = hso_pkg::RP_CYC3 / 10;
   localparam int BLK  = int'(hso_pkg::BLANK_CYC);
   localparam int T_LO = BLK + int'(hso_pkg::DG_CYC0);
   localparam int T_HV = BLK + int'(hso_pkg::DG_CYC_HV);
   localparam int STEP = int'(hso_pkg::GEN_STEP3);
   logic              clock;
   logic              srst;
   logic [15:0]       rdata;
   logic [5:0]        overcurrent;
   logic              supplyHigh;
   logic              externalPwmPin;
   hso_pkg::hso_bus_t bus;
   hso_pkg::hso_drv_t drv;
   logic [15:0]       rd;
   int                n;
   int                error_cnt;
   int                compares;
   int                mark;
   int                tick = 0;
   hso_row_t          rows [6] = '{
      '{2'h0, 1'b1, 1'b0, 1'b0}, '{2'h1, 1'b1, 1'b0, 1'b1},
      '{2'h1, 1'b0, 1'b1, 1'b0}, '{2'h2, 1'b0, 1'b0, 1'b0},
      '{2'h2, 1'b0, 1'b1, 1'b1}, '{2'h2, 1'b1, 1'b0, 1'b0}};

   hso_control #(.CC_TIME_CYC(CC_T), .RP_SCALE(10)) dut_u (
      .clock(clock), .srst(srst), .bus(bus), .rdata(rdata),
      .overcurrent(overcurrent), .supplyHigh(supplyHigh),
      .externalPwmPin(externalPwmPin), .drv(drv));
   hso_host host_u (.clock(clock), .rdata(rdata), .bus(bus),
      .externalPwmPin(externalPwmPin));

   initial begin
      clock = 1'b0;
      forever #4 clock = ~clock;
   end

   // Free-running cycle count for interval measurements.
   always @(posedge clock) begin
      tick <= tick + 1;
   end

   task automatic chk(string nm, logic [15:0] s, logic [15:0] e);
      compares++;
      if (s !== e) begin
         error_cnt++;
         $display("MISMATCH %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic rng(string nm, int v, int lo, int hi);
      chk(nm, 16'(v >= lo && v <= hi), 16'h0001);
   endtask
   task automatic rdChk(string nm, logic [3:0] a, logic [15:0] e);
      host_u.xfer(1'b0, a, 16'h0000, rd);
      chk(nm, rd, e);
   endtask
   task automatic cyc(int k);
      repeat (k) @(posedge clock);
   endtask
   // Counts cycles until the first output reaches a level, bounded.
   task automatic waitDrv(logic v, int lim);
      n = 0;
      while (drv.drive[0] !== v && n < lim) begin
         @(posedge clock);
         n++;
      end
   endtask
   task automatic print_verdict;
      $display("compares %0d mismatches %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   initial begin
      repeat (80000) @(posedge clock);
      error_cnt++;
      print_verdict();
   end

   initial begin
      srst = 1'b1;
      overcurrent = 6'h00;
      supplyHigh = 1'b0;
      error_cnt = 0;
      compares = 0;
      cyc(3);
      srst <= 1'b0;
      chk("drive", 16'(drv.drive), 16'h0000);
      rdChk("reg1", hso_pkg::ADDR_REG1, 16'h0000);
      rdChk("reg3", hso_pkg::ADDR_REG3, 16'h0000);
      rdChk("unmapped", 4'hF, 16'h0000);
      $display("reset test done");
      foreach (rows[i]) begin
         host_u.wr(hso_pkg::ADDR_SOURCE, {14'h0000, rows[i].src});
         host_u.wr(hso_pkg::ADDR_ONCTL, {15'h0000, rows[i].on});
         host_u.pin(rows[i].pin);
         cyc(3);
         chk("row", 16'(drv.drive[0]), 16'(rows[i].exp));
      end
      $display("source table done");
      host_u.wr(hso_pkg::ADDR_SOURCE, 16'h0000);
      host_u.wr(hso_pkg::ADDR_ONCTL, 16'h0001);
      host_u.wr(hso_pkg::ADDR_CCCFG, 16'h0101);
      host_u.wr(hso_pkg::ADDR_SOURCE, 16'h0001);
      cyc(2);
      chk("ccOn", 16'(drv.ccActive[0]), 16'h0001);
      chk("ccLim", 16'(drv.ccLimitHigh[0]), 16'h0001);
      cyc(CC_T - 10);
      chk("ccHold", 16'(drv.ccActive[0]), 16'h0001);
      cyc(12);
      chk("ccEnd", 16'(drv.ccActive[0]), 16'h0000);
      chk("ccAfter", 16'(drv.drive[0]), 16'h0001);
      rdChk("ccCfg", hso_pkg::ADDR_CCCFG, 16'h0100);
      host_u.wr(hso_pkg::ADDR_CCCFG, 16'h0001);
      rdChk("ccLate", hso_pkg::ADDR_CCCFG, 16'h0000);
      host_u.wr(hso_pkg::ADDR_SOURCE, 16'h0000);
      host_u.wr(hso_pkg::ADDR_CCCFG, 16'h0001);
      host_u.wr(hso_pkg::ADDR_SOURCE, 16'h0001);
      host_u.wr(hso_pkg::ADDR_CCCFG, 16'h0000);
      cyc(2);
      chk("ccClr", 16'(drv.ccActive[0]), 16'h0000);
      chk("ccClrOn", 16'(drv.drive[0]), 16'h0001);
      $display("timed current test done");
      host_u.wr(hso_pkg::ADDR_SOURCE, 16'h0000);
      overcurrent <= 6'h01;
      host_u.wr(hso_pkg::ADDR_SOURCE, 16'h0001);
      waitDrv(1'b1, 8);
      waitDrv(1'b0, 12000);
      rng("ocOff", n, T_LO - 4, T_LO + 3);
      rdChk("noStat", hso_pkg::ADDR_STATUS, 16'h0000);
      overcurrent <= 6'h00;
      host_u.wr(hso_pkg::ADDR_CLRFLT, 16'h0001);
      cyc(3);
      chk("ocClr", 16'(drv.drive[0]), 16'h0001);
      $display("overcurrent test done");
      host_u.wr(hso_pkg::ADDR_REG1, 16'h0F01);
      supplyHigh <= 1'b1;
      host_u.wr(hso_pkg::ADDR_SOURCE, 16'h0000);
      overcurrent <= 6'h01;
      host_u.wr(hso_pkg::ADDR_SOURCE, 16'h0001);
      waitDrv(1'b1, 8);
      waitDrv(1'b0, 8000);
      rng("regOff", n, T_HV - 4, T_HV + 3);
      rdChk("trip", hso_pkg::ADDR_STATUS, 16'h0001);
      waitDrv(1'b1, RP);
      rng("retry", n, 1, RP - 1);
      waitDrv(1'b0, 8000);
      rng("reOff", n, T_HV - 2, T_HV + 2);
      waitDrv(1'b1, RP);
      rng("period", n, RP - T_HV - 3, RP - T_HV + 3);
      overcurrent <= 6'h00;
      supplyHigh <= 1'b0;
      rdChk("latch", hso_pkg::ADDR_STATUS, 16'h0001);
      host_u.wr(hso_pkg::ADDR_CLRFLT, 16'h0001);
      rdChk("cleared", hso_pkg::ADDR_STATUS, 16'h0000);
      $display("regulation test done");
      srst <= 1'b1;
      cyc(3);
      srst <= 1'b0;
      chk("drvRst", 16'(drv.drive), 16'h0000);
      rdChk("reg1Rst", hso_pkg::ADDR_REG1, 16'h0000);
      host_u.wr(hso_pkg::ADDR_FREQ, 16'h0003);
      host_u.wr(hso_pkg::ADDR_DUTY0, 16'h0001);
      host_u.wr(hso_pkg::ADDR_SOURCE, 16'h0003);
      waitDrv(1'b1, 300);
      waitDrv(1'b0, 400);
      mark = tick;
      host_u.wr(hso_pkg::ADDR_DUTY0, 16'h0002);
      waitDrv(1'b1, 8);
      waitDrv(1'b0, 400);
      chk("genStep", 16'(tick - mark), 16'(STEP));
      $display("generator test done");
      print_verdict();
   end
endmodule
